/* verilog/sfr_fault_core.v */
`timescale 1ns/10ps
`include "sfr_regs.vh"
// Notes on behaviour
// - Default trip: 2x breaker, 1.5x inrush
// - Setup bits 12:11 pick steady multiplier
// - Above scaled level: FET off in delay
// - Fixed higher level: FET off in delay
// - Retry-select bit chooses fast-trip response
// - Retry-select 0: latch fault, await restart
// - Latched short sets listed status flags
// - Alert if unmasked and alert pin configured
// - Power-good drops when pin configured
// - Fault pin if masked-in and configured
// - Retry-select 1: FET on after 30us
// - Persistent short: limit, thermal, latch off
// - Retry-mode fault sets thermal status flags
// - Retry fault pin needs safe-area, temp mask
// - Masked line transient sets transient flag
// - Disable bit stops transient trip masking
// - Open load-sense pin forces breaker trip
// - Backup trip, no load-sense trip: latch
// - Open limit-sense pin forces current limit
// - Backup trip, no limit-sense trip: latch
// - Restart policy: stay off or retry
module sfr_fault_core
#(
    parameter LW           = 16,
    parameter DEGLITCH_CYC = `SFR_DEGLITCH_CYC
)
(
    input  wire          i_core_clk,
    input  wire          i_rst,
    input  wire [15:0]   i_setup,
    input  wire [LW-1:0] i_breaker_level,
    input  wire [LW-1:0] i_inrush_limit_level,
    input  wire [LW-1:0] i_fixed_trip_level,
    input  wire [LW-1:0] i_load_current,
    input  wire          i_inrush,
    input  wire          i_line_transient,
    input  wire          i_load_sense_pin_open,
    input  wire          i_load_sense_trip,
    input  wire          i_startup_limit_sense_pin_open,
    input  wire          i_startup_limit_trip,
    input  wire          i_backup_trip,
    input  wire          i_thermal_shutdown,
    input  wire          i_restart,
    input  wire          i_auto_retry_en,
    input  wire          i_auto_retry_done,
    input  wire [3:0]    i_alert_mask,
    input  wire [3:0]    i_fault_pin_mask,
    input  wire          i_gpio4_is_alert,
    input  wire          i_gpio1_is_power_good,
    input  wire          i_gpio2_is_fault,
    input  wire          i_status_clear,
    output reg           o_fet_on,
    output reg           o_current_limit,
    output reg           o_breaker_trip,
    output reg  [7:0]    o_status_byte,
    output reg  [7:0]    o_status_word_hi,
    output reg  [7:0]    o_status_out,
    output reg  [7:0]    o_status_temp,
    output reg  [7:0]    o_vendor_status_one,
    output reg  [7:0]    o_vendor_status_two,
    output reg           o_alert_n,
    output reg           o_power_good_out,
    output reg           o_fault_out_n,
    output reg  [LW+3:0] o_scaled_trip_level
);
    localparam [3:0] ST_ON      = 4'h1;
    localparam [3:0] ST_DEGLIT  = 4'h2;
    localparam [3:0] ST_RETRYON = 4'h4;
    localparam [3:0] ST_LATCH   = 4'h8;
    localparam [15:0] DG_CNT    = DEGLITCH_CYC - 1;

    wire [8:0]    sy;
    wire          line_tran;
    wire          ls_open;
    wire          ls_trip;
    wire          sl_open;
    wire          sl_trip;
    wire          bkp_trip;
    wire          tsd;
    wire          restart;
    wire          retry_done;
    wire [LW+3:0] lvl;
    wire [LW+3:0] cur_x4;
    wire [LW+3:0] fixed_x4;
    wire          retry_sel;
    wire          tran_dis;
    wire          sft_hit;
    wire          fft_hit;
    wire          fast_trip;
    wire          tran_masked;
    wire          spf;
    wire          go_restart;

    reg  [3:0]    state_reg;
    reg  [3:0]    state_next;
    reg  [15:0]   cnt_reg;
    reg           mode_retry_reg;
    reg           sc_evt;
    reg           therm_evt;
    reg           spf_evt;
    reg           sc_lat_reg;
    reg           therm_lat_reg;
    reg           spf_lat_reg;

    sfr_sync #(.W(9)) u_sync
    (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_async    ({i_line_transient, i_load_sense_pin_open, i_load_sense_trip,
                      i_startup_limit_sense_pin_open, i_startup_limit_trip, i_backup_trip,
                      i_thermal_shutdown, i_restart, i_auto_retry_done}),
        .o_sync     (sy)
    );
    assign {line_tran, ls_open, ls_trip, sl_open, sl_trip, bkp_trip, tsd, restart, retry_done} = sy;

    sfr_trip_level #(.LW(LW)) u_lvl
    (
        .i_breaker_level      (i_breaker_level),
        .i_inrush_limit_level (i_inrush_limit_level),
        .i_mult_sel           (i_setup[`SFR_MULT_MSB:`SFR_MULT_LSB]),
        .i_inrush             (i_inrush),
        .o_scaled_trip_level  (lvl)
    );

    assign retry_sel = i_setup[`SFR_RETRY_BIT];
    assign tran_dis  = i_setup[`SFR_TRAN_DIS_BIT];
    assign cur_x4    = {i_load_current, 2'h0, 2'h0} >> 2;
    assign fixed_x4  = {i_fixed_trip_level, 2'h0, 2'h0} >> 2;
    assign sft_hit   = cur_x4 > lvl;
    assign fft_hit   = ~i_inrush & (cur_x4 > fixed_x4);
    // Line transient suppresses a trip unless the feature is disabled
    assign tran_masked = line_tran & ~tran_dis & (sft_hit | fft_hit);
    assign fast_trip   = (sft_hit | fft_hit) & ~tran_masked;
    // Backup sense fired while the primary sense stayed quiet
    assign spf = bkp_trip & ((~i_inrush & ~ls_trip) | (i_inrush & ~sl_trip));
    assign go_restart = restart | (i_auto_retry_en & retry_done);

    always @*
    begin
        state_next = state_reg;
        sc_evt     = 1'b0;
        therm_evt  = 1'b0;
        spf_evt    = 1'b0;
        case (state_reg)
            ST_ON:
            begin
                if (spf)
                begin
                    spf_evt    = 1'b1;
                    state_next = ST_LATCH;
                end
                else if (fast_trip & ~retry_sel)
                begin
                    sc_evt     = 1'b1;
                    state_next = ST_LATCH;
                end
                else if (fast_trip)
                    state_next = ST_DEGLIT;
            end
            ST_DEGLIT:
            begin
                if (spf)
                begin
                    spf_evt    = 1'b1;
                    state_next = ST_LATCH;
                end
                else if (cnt_reg == DG_CNT)
                    state_next = ST_RETRYON;
            end
            ST_RETRYON:
            begin
                if (spf)
                begin
                    spf_evt    = 1'b1;
                    state_next = ST_LATCH;
                end
                else if (tsd)
                begin
                    therm_evt  = 1'b1;
                    state_next = ST_LATCH;
                end
                else if (~(sft_hit | fft_hit))
                    state_next = ST_ON;
            end
            ST_LATCH:
            begin
                if (go_restart)
                    state_next = ST_ON;
            end
            default: state_next = ST_ON;
        endcase
    end

    always @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            state_reg      <= ST_ON;
            cnt_reg        <= 16'h0000;
            mode_retry_reg <= 1'b0;
            sc_lat_reg     <= 1'b0;
            therm_lat_reg  <= 1'b0;
            spf_lat_reg    <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= (state_reg == ST_DEGLIT) ? cnt_reg + 16'h0001 : 16'h0000;
            if (sc_evt | therm_evt | spf_evt)
                mode_retry_reg <= therm_evt;
            // Set wins over a clear in the same cycle
            sc_lat_reg    <= sc_evt | (sc_lat_reg & ~i_status_clear);
            therm_lat_reg <= therm_evt | (therm_lat_reg & ~i_status_clear);
            spf_lat_reg   <= spf_evt | (spf_lat_reg & ~i_status_clear);
        end
    end

    always @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_fet_on            <= 1'b1;
            o_current_limit     <= 1'b0;
            o_breaker_trip      <= 1'b0;
            o_status_byte       <= 8'h00;
            o_status_word_hi    <= 8'h00;
            o_status_out        <= 8'h00;
            o_status_temp       <= 8'h00;
            o_vendor_status_one <= 8'h00;
            o_vendor_status_two <= 8'h00;
            o_alert_n           <= 1'b1;
            o_power_good_out    <= 1'b0;
            o_fault_out_n       <= 1'b1;
            o_scaled_trip_level <= {(LW+4){1'b0}};
        end
        else
        begin
            o_scaled_trip_level <= lvl;
            o_fet_on        <= (state_next == ST_ON) | (state_next == ST_RETRYON);
            o_current_limit <= (state_next == ST_RETRYON) | sl_open;
            o_breaker_trip  <= ls_open;
            if (sc_evt)
            begin
                o_status_byte[`SFR_SB_FET_OFF]       <= 1'b1;
                o_status_byte[`SFR_SB_NONE]          <= 1'b1;
                o_status_word_hi[`SFR_SW_OUT]        <= 1'b1;
                o_status_word_hi[`SFR_SW_POWER_NOT_GOOD_FLAG]     <= 1'b1;
                o_status_word_hi[`SFR_SW_NONE]       <= 1'b1;
                o_status_out[`SFR_SO_UV_WARN]        <= 1'b1;
                o_vendor_status_two[`SFR_V2_POWER_NOT_GOOD_FLAG]  <= 1'b1;
                o_vendor_status_two[`SFR_V2_SHORT_FAULT_FLAG]  <= 1'b1;
            end
            else if (therm_evt)
            begin
                o_status_byte[`SFR_SB_FET_OFF]       <= 1'b1;
                o_status_byte[`SFR_SB_TEMP]          <= 1'b1;
                o_status_byte[`SFR_SB_NONE]          <= 1'b1;
                o_status_word_hi[`SFR_SW_OUT]        <= 1'b1;
                o_status_word_hi[`SFR_SW_MFR]        <= 1'b1;
                o_status_word_hi[`SFR_SW_POWER_NOT_GOOD_FLAG]     <= 1'b1;
                o_status_word_hi[`SFR_SW_NONE]       <= 1'b1;
                o_status_out[`SFR_SO_UV_WARN]        <= 1'b1;
                o_status_temp[`SFR_ST_OVERTEMP_FAULT_FLAG]        <= 1'b1;
                o_vendor_status_one[`SFR_V1_SOA]     <= 1'b1;
                o_vendor_status_two[`SFR_V2_POWER_NOT_GOOD_FLAG]  <= 1'b1;
            end
            else if (i_status_clear)
            begin
                o_status_byte       <= 8'h00;
                o_status_word_hi    <= 8'h00;
                o_status_out        <= 8'h00;
                o_status_temp       <= 8'h00;
                o_vendor_status_one <= 8'h00;
                o_vendor_status_two <= 8'h00;
            end
            if (spf_evt)
                o_vendor_status_two[`SFR_V2_SINGLE_POINT_FAIL_FLAG] <= 1'b1;
            if (tran_masked)
                o_vendor_status_two[`SFR_V2_TRAN] <= 1'b1;
            // Alert: latched short needs power-not-good and output unmasked
            o_alert_n <= ~(i_gpio4_is_alert & (spf_lat_reg
                | (sc_lat_reg & ~i_alert_mask[`SFR_AM_POWER_NOT_GOOD_FLAG] & ~i_alert_mask[`SFR_AM_OUT])
                | (therm_lat_reg & ~i_alert_mask[`SFR_AM_POWER_NOT_GOOD_FLAG] & ~i_alert_mask[`SFR_AM_OUT]
                   & ~i_alert_mask[`SFR_AM_MFR] & ~i_alert_mask[`SFR_AM_TEMP])));
            o_power_good_out <= i_gpio1_is_power_good & (state_reg == ST_ON)
                & ~sc_lat_reg & ~therm_lat_reg;
            o_fault_out_n <= ~(i_gpio2_is_fault & (spf_lat_reg
                | (sc_lat_reg & i_fault_pin_mask[`SFR_FM_SC])
                | (therm_lat_reg & i_fault_pin_mask[`SFR_FM_SOA] & i_fault_pin_mask[`SFR_FM_TEMP])));
        end
    end
endmodule

/* inc/sfr_regs.vh */
`ifndef SFR_REGS_VH
`define SFR_REGS_VH

// Steady-state fast-trip multiplier codes, field position in setup word
`define SFR_MULT_LSB        11
`define SFR_MULT_MSB        12
`define SFR_MULT_1P50       2'h0
`define SFR_MULT_2P00       2'h1
`define SFR_MULT_1P75       2'h2
`define SFR_MULT_2P25       2'h3
`define SFR_MULT_RESET      2'h1
// Multiplier expressed in quarters (x4)
`define SFR_Q_1P50          4'h6
`define SFR_Q_2P00          4'h8
`define SFR_Q_1P75          4'h7
`define SFR_Q_2P25          4'h9
// Setup word bit positions
`define SFR_RETRY_BIT       0
`define SFR_TRAN_DIS_BIT    1
// Timing
`define SFR_CLK_MHZ         100
`define SFR_DEGLITCH_US     30
`define SFR_DEGLITCH_CYC    (`SFR_DEGLITCH_US * `SFR_CLK_MHZ)
// Status byte bits
`define SFR_SB_NONE         0
`define SFR_SB_TEMP         2
`define SFR_SB_FET_OFF      6
// Status word upper byte bits
`define SFR_SW_NONE         0
`define SFR_SW_POWER_NOT_GOOD_FLAG       3
`define SFR_SW_MFR          4
`define SFR_SW_OUT          7
// Status out bit
`define SFR_SO_UV_WARN      5
// Status temp bit
`define SFR_ST_OVERTEMP_FAULT_FLAG       7
// Vendor status one bit
`define SFR_V1_SOA          0
// Vendor status two bits
`define SFR_V2_SHORT_FAULT_FLAG       0
`define SFR_V2_TRAN         1
`define SFR_V2_SINGLE_POINT_FAIL_FLAG       2
`define SFR_V2_POWER_NOT_GOOD_FLAG       3
// Alert mask bits (1 = masked)
`define SFR_AM_POWER_NOT_GOOD_FLAG       0
`define SFR_AM_OUT          1
`define SFR_AM_MFR          2
`define SFR_AM_TEMP         3
// Fault pin mask bits (1 = enabled)
`define SFR_FM_SC           0
`define SFR_FM_SOA          1
`define SFR_FM_TEMP         2
`define SFR_FM_SPF          3

`endif

/* verilog/sfr_sync.v */
`timescale 1ns/10ps
module sfr_sync
#(
    parameter W = 1
)
(
    input  wire         i_core_clk,
    input  wire         i_rst,
    input  wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1)
        begin : g_bit
            reg meta_reg;
            reg sync_reg;
            always @(posedge i_core_clk)
            begin
                if (i_rst)
                begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                end
                else
                begin
                    meta_reg <= i_async[g];
                    sync_reg <= meta_reg;
                end
            end
            assign o_sync[g] = sync_reg;
        end
    endgenerate
endmodule

/* verilog/sfr_trip_level.v */
`timescale 1ns/10ps
`include "sfr_regs.vh"
module sfr_trip_level
#(
    parameter LW = 16
)
(
    input  wire [LW-1:0] i_breaker_level,
    input  wire [LW-1:0] i_inrush_limit_level,
    input  wire [1:0]    i_mult_sel,
    input  wire          i_inrush,
    output wire [LW+3:0] o_scaled_trip_level
);
    reg  [3:0]    quarters;
    wire [LW+3:0] ss_level;
    wire [LW+3:0] in_level;

    always @*
    begin
        case (i_mult_sel)
            `SFR_MULT_1P50: quarters = `SFR_Q_1P50;
            `SFR_MULT_2P00: quarters = `SFR_Q_2P00;
            `SFR_MULT_1P75: quarters = `SFR_Q_1P75;
            default:        quarters = `SFR_Q_2P25;
        endcase
    end

    // Levels scaled by four; comparisons scale current the same way
    assign ss_level = {4'h0, i_breaker_level} * {{LW{1'b0}}, quarters};
    assign in_level = {4'h0, i_inrush_limit_level} * {{LW{1'b0}}, `SFR_Q_1P50};
    assign o_scaled_trip_level = i_inrush ? in_level : ss_level;
endmodule

/* tb/sfr_fault_monitor.sv */
`timescale 1ns/10ps
`include "sfr_regs.vh"
module sfr_fault_monitor
#(
    parameter LW           = 16,
    parameter DEGLITCH_CYC = 8
)
(
    input wire          i_core_clk,
    input wire          i_rst,
    input wire [15:0]   i_setup,
    input wire [LW-1:0] i_breaker_level,
    input wire [LW-1:0] i_inrush_limit_level,
    input wire [LW-1:0] i_load_current,
    input wire          i_inrush,
    input wire          i_line_transient,
    input wire          i_load_sense_pin_open,
    input wire          i_load_sense_trip,
    input wire          i_startup_limit_trip,
    input wire          i_backup_trip,
    input wire          i_restart,
    input wire          i_auto_retry_en,
    input wire [3:0]    i_alert_mask,
    input wire          i_gpio4_is_alert,
    input wire          i_gpio1_is_power_good,
    input wire          i_gpio2_is_fault,
    input wire          o_fet_on,
    input wire          o_breaker_trip,
    input wire [7:0]    o_status_temp,
    input wire [7:0]    o_vendor_status_two,
    input wire          o_alert_n,
    input wire          o_power_good_out,
    input wire          o_fault_out_n,
    input wire [LW+3:0] o_scaled_trip_level
);
    reg  [15:0] off_cnt_reg;
    wire [1:0]  code = i_setup[`SFR_MULT_MSB:`SFR_MULT_LSB];
    wire [3:0]  mult_q = (code == 2'h0) ? 4'h6 : (code == 2'h1) ? 4'h8 : (code == 2'h2) ? 4'h7 : 4'h9;

    // Counts consecutive cycles with the FET held off
    always @(posedge i_core_clk)
    begin
        if (i_rst || o_fet_on)
            off_cnt_reg <= 16'h0000;
        else
            off_cnt_reg <= off_cnt_reg + 16'h0001;
    end

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    sequence s_over;
        o_fet_on && ({2'h0, i_load_current, 2'h0} > o_scaled_trip_level);
    endsequence
    sequence s_spf_cause;
        i_backup_trip && !i_load_sense_trip && !i_startup_limit_trip;
    endsequence

    a_steady_level: assert property (!$past(i_rst) && !$past(i_inrush)
        |-> o_scaled_trip_level == $past(i_breaker_level) * $past(mult_q)) else $error("steady trip level wrong");
    a_inrush_level: assert property (!$past(i_rst) && $past(i_inrush)
        |-> o_scaled_trip_level == $past(i_inrush_limit_level) * 4'h6) else $error("inrush trip level wrong");
    a_trip_fet_off: assert property (s_over ##0 i_setup[`SFR_TRAN_DIS_BIT] |-> ##[1:3] !o_fet_on)
        else $error("fet not off after trip");
    a_latch_holds: assert property (!o_fet_on && !i_setup[`SFR_RETRY_BIT] && !i_auto_retry_en && !i_restart
        && !$past(i_restart) && !$past(i_restart, 2) && !$past(i_restart, 3) |=> !o_fet_on) else $error("latch lost");
    a_reclose_early: assert property ($rose(o_fet_on) && i_setup[`SFR_RETRY_BIT]
        |-> off_cnt_reg >= DEGLITCH_CYC - 1) else $error("reclose before deglitch");
    a_reclose_late: assert property (i_setup[`SFR_RETRY_BIT] && o_status_temp == 8'h00 && !o_breaker_trip
        && !o_vendor_status_two[`SFR_V2_SINGLE_POINT_FAIL_FLAG] |-> off_cnt_reg <= DEGLITCH_CYC + 4) else $error("no reclose");
    a_alert_short: assert property ($rose(o_vendor_status_two[`SFR_V2_SHORT_FAULT_FLAG]) && i_gpio4_is_alert
        && !i_alert_mask[`SFR_AM_POWER_NOT_GOOD_FLAG] && !i_alert_mask[`SFR_AM_OUT] |-> ##[0:2] !o_alert_n) else $error("no alert");
    a_pg_drop: assert property ($fell(o_fet_on) && i_gpio1_is_power_good |-> ##[0:2] !o_power_good_out)
        else $error("power good kept");
    a_fault_unconf: assert property (!i_gpio2_is_fault && !$past(i_gpio2_is_fault) |-> o_fault_out_n)
        else $error("fault pin driven while unconfigured");
    a_transient_mask: assert property (!i_setup[`SFR_TRAN_DIS_BIT] && o_fet_on && i_line_transient [*4]
        |=> o_fet_on) else $error("trip during masked transient");
    a_open_sense: assert property (i_load_sense_pin_open [*3] |-> ##[1:2] o_breaker_trip)
        else $error("open sense pin no breaker trip");
    a_spf_latch: assert property (s_spf_cause [*3] |-> ##[1:2] (!o_fet_on && o_vendor_status_two[`SFR_V2_SINGLE_POINT_FAIL_FLAG]))
        else $error("single point fault not latched");
endmodule
bind sfr_fault_core sfr_fault_monitor #(.LW(LW), .DEGLITCH_CYC(DEGLITCH_CYC)) i_mon (.i_core_clk, .i_rst, .i_setup,
    .i_breaker_level, .i_inrush_limit_level, .i_load_current, .i_inrush, .i_line_transient, .i_load_sense_pin_open,
    .i_load_sense_trip, .i_startup_limit_trip, .i_backup_trip, .i_restart, .i_auto_retry_en, .i_alert_mask,
    .i_gpio4_is_alert, .i_gpio1_is_power_good, .i_gpio2_is_fault, .o_fet_on, .o_breaker_trip, .o_status_temp,
    .o_vendor_status_two, .o_alert_n, .o_power_good_out, .o_fault_out_n, .o_scaled_trip_level);

/* tb/sfr_host_model.sv */
`timescale 1ns/10ps
module sfr_host_model
(
    input  wire       i_core_clk,
    input  wire       i_rst,
    input  wire       i_alert_n,
    input  wire       i_clear_req,
    output reg        o_status_clear,
    output reg  [7:0] o_alert_count
);
    reg alert_n_reg;

    // Counts alert assertions and issues a status clear one cycle after each clear request
    always @(posedge i_core_clk)
    begin
        o_status_clear <= i_clear_req;
        alert_n_reg    <= i_alert_n;
        if (i_rst)
            o_alert_count <= 8'h00;
        else if (alert_n_reg && !i_alert_n)
            o_alert_count <= o_alert_count + 8'h01;
    end
endmodule

/* tb/short_circuit_fault_response_bench.sv */
`timescale 1ns/10ps
module short_circuit_fault_response_bench;
    reg         clk, rst, clr_req;
    reg  [7:0]  ev;
    reg  [3:0]  cfg, am, fm;
    reg  [15:0] setup, brk, inl, fix, cur;
    wire        fet, clim, btrip, an, pg, fn, sclr;
    wire [7:0]  sb, sw, so, st, v1, v2, acnt;
    wire [19:0] lvl;
    integer     errors, checks_done, k;

    // Event bits: 0 transient, 1 load pin open, 2 limit pin open, 3 backup, 4 thermal, 5 restart, 6 retry done, 7 inrush
    sfr_fault_core #(.LW(16), .DEGLITCH_CYC(8)) i_dut (.i_core_clk(clk), .i_rst(rst), .i_setup(setup),
        .i_breaker_level(brk), .i_inrush_limit_level(inl), .i_fixed_trip_level(fix), .i_load_current(cur),
        .i_inrush(ev[7]), .i_line_transient(ev[0]), .i_load_sense_pin_open(ev[1]), .i_load_sense_trip(1'b0),
        .i_startup_limit_sense_pin_open(ev[2]), .i_startup_limit_trip(1'b0), .i_backup_trip(ev[3]),
        .i_thermal_shutdown(ev[4]), .i_restart(ev[5]), .i_auto_retry_en(cfg[3]), .i_auto_retry_done(ev[6]),
        .i_alert_mask(am), .i_fault_pin_mask(fm), .i_gpio4_is_alert(cfg[0]), .i_gpio1_is_power_good(cfg[1]),
        .i_gpio2_is_fault(cfg[2]), .i_status_clear(sclr), .o_fet_on(fet), .o_current_limit(clim),
        .o_breaker_trip(btrip), .o_status_byte(sb), .o_status_word_hi(sw), .o_status_out(so), .o_status_temp(st),
        .o_vendor_status_one(v1), .o_vendor_status_two(v2), .o_alert_n(an), .o_power_good_out(pg),
        .o_fault_out_n(fn), .o_scaled_trip_level(lvl));
    sfr_host_model i_host (.i_core_clk(clk), .i_rst(rst), .i_alert_n(an), .i_clear_req(clr_req),
        .o_status_clear(sclr), .o_alert_count(acnt));

    function [3:0] q4(input [1:0] c);
        q4 = (c == 2'h0) ? 4'h6 : (c == 2'h1) ? 4'h8 : (c == 2'h2) ? 4'h7 : 4'h9;
    endfunction

    task check(input string what, input [31:0] seen, input [31:0] exp);
    begin
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    end
    endtask

    task conclude;
    begin
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask

    task settle(input integer n);
    begin
        repeat (n) @(posedge clk);
        #1;
    end
    endtask

    task wait_fet(input v);
    begin
        k = 0;
        while (fet !== v && k < 60)
        begin
            @(posedge clk);
            #1;
            k = k + 1;
        end
    end
    endtask

    // Restarts the FET, then has the host clear the sticky status
    task recover;
    begin
        @(posedge clk);
        cur <= 16'h0000;
        ev  <= 8'h20;
        repeat (4) @(posedge clk);
        ev  <= 8'h00;
        settle(1);
        wait_fet(1'b1);
        check("fet_restart", fet, 1'b1);
        @(posedge clk);
        clr_req <= 1'b1;
        @(posedge clk);
        clr_req <= 1'b0;
        settle(3);
        check("status_clr", {sb, sw, so, st}, 32'h0);
        check("vendor_clr", {v1, v2}, 16'h0);
        check("pg_back", pg, 1'b1);
    end
    endtask

    task t_levels;
        integer c;
    begin
        for (c = 0; c < 4; c = c + 1)
        begin
            @(posedge clk);
            setup[12:11] <= c[1:0];
            settle(2);
            check("scaled_level", lvl, brk * q4(c[1:0]));
        end
        @(posedge clk);
        setup <= 16'h0800;
        ev    <= 8'h80;
        settle(2);
        check("inrush_level", lvl, inl * 4'h6);
        @(posedge clk);
        ev    <= 8'h00;
        settle(2);
        check("steady_level", lvl, brk * 4'h8);
    end
    endtask

    task t_latch;
    begin
        @(posedge clk);
        cur <= 16'h00C8;
        settle(6);
        check("fet_at_level", fet, 1'b1);
        @(posedge clk);
        cur <= 16'h00C9;
        settle(1);
        wait_fet(1'b0);
        check("trip_time", k < 3, 1'b1);
        settle(3);
        check("short_status", {sb, sw, so, v2}, 32'h41892009);
        check("short_pins", {an, fn, pg, acnt}, 11'h001);
        @(posedge clk);
        cur <= 16'h0000;
        settle(10);
        check("latched", fet, 1'b0);
        recover;
    end
    endtask

    task t_masked;
    begin
        @(posedge clk);
        am  <= 4'h3;
        cfg <= 4'hB;
        cur <= 16'h00C9;
        settle(1);
        wait_fet(1'b0);
        settle(3);
        check("masked_pins", {fet, an, fn}, 3'h3);
        @(posedge clk);
        cur <= 16'h0000;
        ev  <= 8'h40;
        settle(1);
        wait_fet(1'b1);
        check("auto_retry", fet, 1'b1);
        @(posedge clk);
        ev  <= 8'h00;
        am  <= 4'h0;
        cfg <= 4'h7;
        recover;
    end
    endtask

    task t_retry;
    begin
        @(posedge clk);
        setup <= 16'h0801;
        fm    <= 4'h6;
        cur   <= 16'h00C9;
        repeat (2) @(posedge clk);
        cur   <= 16'h0000;
        settle(1);
        wait_fet(1'b0);
        wait_fet(1'b1);
        // FET fell two edges before this count began, so the off time is k plus two
        check("deglitch", (k + 2) >= 7 && (k + 2) <= 11, 1'b1);
        @(posedge clk);
        cur <= 16'h00C9;
        repeat (20) @(posedge clk);
        ev  <= 8'h10;
        settle(6);
        check("retry_status", {sb, sw, so, st}, 32'h45992080);
        check("retry_pins", {fet, v1[0], v2[3], fn}, 4'h6);
        @(posedge clk);
        ev  <= 8'h00;
        cur <= 16'h0000;
        settle(8);
        check("tsd_latched", fet, 1'b0);
        recover;
        @(posedge clk);
        setup <= 16'h0800;
        fm    <= 4'h1;
    end
    endtask

    task t_transient;
    begin
        @(posedge clk);
        ev <= 8'h01;
        repeat (4) @(posedge clk);
        cur <= 16'h00C9;
        settle(6);
        check("masked_trip", {fet, v2[1]}, 2'h3);
        @(posedge clk);
        setup <= 16'h0802;
        settle(1);
        wait_fet(1'b0);
        check("unmasked_trip", fet, 1'b0);
        @(posedge clk);
        setup <= 16'h0800;
        recover;
    end
    endtask

    task t_faults;
    begin
        @(posedge clk);
        brk <= 16'h1000;
        fix <= 16'h012C;
        cur <= 16'h012D;
        settle(1);
        wait_fet(1'b0);
        check("fixed_trip", fet, 1'b0);
        @(posedge clk);
        brk <= 16'h0064;
        fix <= 16'hFFFF;
        recover;
        @(posedge clk);
        ev <= 8'h02;
        settle(5);
        check("open_load_pin", btrip, 1'b1);
        @(posedge clk);
        ev <= 8'h84;
        settle(5);
        check("open_limit_pin", clim, 1'b1);
        recover;
        @(posedge clk);
        ev <= 8'h08;
        settle(1);
        wait_fet(1'b0);
        settle(3);
        check("spf_latch", {fet, fn, an, v2[2]}, 4'h1);
        recover;
    end
    endtask

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        #50000;
        errors = errors + 1;
        conclude;
    end

    initial
    begin
        errors      = 0;
        checks_done = 0;
        rst         = 1'b1;
        clr_req     = 1'b0;
        ev          = 8'h00;
        cfg         = 4'h7;
        am          = 4'h0;
        fm          = 4'h1;
        setup       = 16'h0800;
        brk         = 16'h0064;
        inl         = 16'h0028;
        fix         = 16'hFFFF;
        cur         = 16'h0000;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        settle(3);
        t_levels;
        t_latch;
        t_masked;
        t_retry;
        t_transient;
        t_faults;
        conclude;
    end
endmodule
